/* File: inc/pcm_pkg.sv */
// Constants, register map and carrier types for the program counter monitor.
// Assumes a single AHB-Lite slave on hclk; register byte address is index * 4.
// Functional notes
// R1: Live counter low bits readable, reset zero.
// R2: Clear bit set forces counter zero, frozen.
// R3: Clear bit zero lets counter advance.
// R4: Clear bit is bit zero, resets zero.
// R5: Clear set then released zeroes all-time max.
// R6: Peak of last frame or block captured.
// R7: Frame peak upper byte in low bits.
// R8: Frame peak lower sixteen bits readable.
// R9: Clear bit also clears frame peak.
// R10: All-time max kept across frames until cleared.
// R11: All-time max upper byte in low bits.
// R12: All-time max lower sixteen bits readable.
// R13: Frame end raises all-time max if larger.
package pcm_pkg;

    localparam int          PCM_PC_W      = 24;
    localparam int          PCM_IDX_W     = 16;
    localparam int          PCM_IDX_LSB   = 2;

    // Register indices; byte address is index shifted left by two
    localparam logic [15:0] PCM_IDX_PC_HI = 16'hf460;
    localparam logic [15:0] PCM_IDX_PC_LO = 16'hf461;
    localparam logic [15:0] PCM_IDX_CLR   = 16'hf462;
    localparam logic [15:0] PCM_IDX_FP_HI = 16'hf463;
    localparam logic [15:0] PCM_IDX_FP_LO = 16'hf464;
    localparam logic [15:0] PCM_IDX_AT_HI = 16'hf465;
    localparam logic [15:0] PCM_IDX_AT_LO = 16'hf466;

    localparam int          PCM_CLR_BIT   = 0;
    localparam logic        PCM_CLR_RST   = 1'b0;
    localparam logic [23:0] PCM_PC_RST    = 24'h000000;
    localparam logic [31:0] PCM_RD_ZERO   = 32'h00000000;

    // AHB address phase captured for the following data phase
    typedef struct packed {
        logic                 wr;
        logic                 valid;
        logic [PCM_IDX_W-1:0] idx;
    } pcm_aphase_t;

endpackage : pcm_pkg

/* File: src/pcm_monitor.sv */
// Program counter monitor: live counter, frame peak and all-time peak.
// Assumes the core drives step, jump and frame_end on hclk; one AHB-Lite master.
`timescale 1ns/1ps
module pcm_monitor
    import pcm_pkg::*;
#(
    parameter int PC_W = PCM_PC_W
)
(
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // DSP core sequencing
    input  wire logic            core_step,
    input  wire logic            core_jump,
    input  wire logic [PC_W-1:0] core_target,
    input  wire logic            frame_end,
    // Counter back to the core
    output logic      [PC_W-1:0] pc_value,
    output logic                 pc_frozen
);

    ////////////////////////////////////////////////////////////////////////
    // State
    pcm_aphase_t      aph_ff;
    logic [31:0]      rdata_ff;
    logic             ready_ff;
    logic             pc_clear_bit_ff;
    logic             clr_prev_ff;
    logic [PC_W-1:0]  pc_ff;
    logic [PC_W-1:0]  run_peak_ff;
    logic [PC_W-1:0]  frame_peak_ff;
    logic [PC_W-1:0]  alltime_peak_ff;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire              take     = hsel & hready & htrans[1];
    wire [15:0]       rd_idx   = haddr[PCM_IDX_LSB +: PCM_IDX_W];
    wire              wr_clr   = aph_ff.valid & aph_ff.wr & (aph_ff.idx == PCM_IDX_CLR);
    pcm_aphase_t      nxt_aph;
    assign nxt_aph.wr    = hwrite;
    assign nxt_aph.valid = take;
    assign nxt_aph.idx   = rd_idx;

    wire [7:0]        pc_high_register   = pc_ff[23:16];
    wire [15:0]       pc_low_bits        = pc_ff[15:0];
    wire [7:0]        frame_peak_upper   = frame_peak_ff[23:16];
    wire [15:0]       frame_peak_lower   = frame_peak_ff[15:0];
    wire [7:0]        alltime_peak_upper = alltime_peak_ff[23:16];
    wire [15:0]       alltime_peak_lower = alltime_peak_ff[15:0];

    // Reserved bits read zero; unmapped indices read zero with OKAY
    logic [31:0] rd_mux;
    always_comb
    begin
        case (rd_idx)
            PCM_IDX_PC_HI: rd_mux = {24'h000000, pc_high_register};
            PCM_IDX_PC_LO: rd_mux = {16'h0000, pc_low_bits}; // R1
            PCM_IDX_CLR:   rd_mux = {31'h00000000, pc_clear_bit_ff};
            PCM_IDX_FP_HI: rd_mux = {24'h000000, frame_peak_upper}; // R7
            PCM_IDX_FP_LO: rd_mux = {16'h0000, frame_peak_lower}; // R8
            PCM_IDX_AT_HI: rd_mux = {24'h000000, alltime_peak_upper}; // R11
            PCM_IDX_AT_LO: rd_mux = {16'h0000, alltime_peak_lower}; // R12
            default:       rd_mux = PCM_RD_ZERO;
        endcase
    end

    wire [31:0]       nxt_rdata = (take & ~hwrite) ? rd_mux : rdata_ff;
    wire              nxt_clear = wr_clr ? hwdata[PCM_CLR_BIT] : pc_clear_bit_ff; // R4

    ////////////////////////////////////////////////////////////////////////
    // Counter and peaks
    wire [PC_W-1:0]   pc_inc    = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
    wire [PC_W-1:0]   nxt_pc    = pc_clear_bit_ff ? PCM_PC_RST :          // R2
                                  core_jump       ? core_target :         // R3
                                  core_step       ? pc_inc : pc_ff;       // R3
    // Peak includes the value held in the cycle of the boundary itself
    wire [PC_W-1:0]   cand      = (pc_ff > run_peak_ff) ? pc_ff : run_peak_ff;
    wire              released  = clr_prev_ff & ~pc_clear_bit_ff;
    wire [PC_W-1:0]   nxt_run   = pc_clear_bit_ff ? PCM_PC_RST :
                                  frame_end       ? nxt_pc : cand;
    wire [PC_W-1:0]   nxt_frame = pc_clear_bit_ff ? PCM_PC_RST :          // R9
                                  frame_end       ? cand : frame_peak_ff; // R6
    // Release of the clear bit beats a frame end in the same cycle
    wire [PC_W-1:0]   nxt_all   = released ? PCM_PC_RST :                 // R5
                                  (frame_end & ~pc_clear_bit_ff & (cand > alltime_peak_ff))
                                  ? cand : alltime_peak_ff;               // R13 R10

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aph_ff   <= '0;
            rdata_ff <= PCM_RD_ZERO;
            ready_ff <= 1'b0;
        end
        else
        begin
            aph_ff   <= nxt_aph;
            rdata_ff <= nxt_rdata;
            ready_ff <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_clear_bit_ff <= PCM_CLR_RST;
            clr_prev_ff     <= PCM_CLR_RST;
        end
        else
        begin
            pc_clear_bit_ff <= nxt_clear;
            clr_prev_ff     <= pc_clear_bit_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_ff           <= PCM_PC_RST;
            run_peak_ff     <= PCM_PC_RST;
            frame_peak_ff   <= PCM_PC_RST;
            alltime_peak_ff <= PCM_PC_RST;
        end
        else
        begin
            pc_ff           <= nxt_pc;
            run_peak_ff     <= nxt_run;
            frame_peak_ff   <= nxt_frame;
            alltime_peak_ff <= nxt_all;
        end
    end

    assign hrdata    = rdata_ff;
    assign hreadyout = ready_ff;
    assign hresp     = 1'b0;
    assign pc_value  = pc_ff;
    assign pc_frozen = pc_clear_bit_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence seq_clr_pulse;
        pc_clear_bit_ff ##1 !pc_clear_bit_ff;
    endsequence

    sequence seq_rd_take(logic [15:0] idx);
        take && !hwrite && (rd_idx == idx);
    endsequence

    AST_PC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        pc_clear_bit_ff |=> (pc_ff == PCM_PC_RST))
        else $error("Counter not held at zero while clear set");

    AST_PC_RUN: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        (!pc_clear_bit_ff && core_step && !core_jump) |=> (pc_ff == $past(pc_inc)))
        else $error("Counter did not advance with clear low");

    AST_CLR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        (take && hwrite && rd_idx == PCM_IDX_CLR) ##1 1'b1
        |=> (pc_clear_bit_ff == $past(hwdata[PCM_CLR_BIT])))
        else $error("Clear bit did not take written value");

    AST_MAX_CLEARED: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        seq_clr_pulse |=> (alltime_peak_ff == PCM_PC_RST))
        else $error("All-time peak not cleared after clear pulse");

    AST_FRAME_CAP: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        (frame_end && !pc_clear_bit_ff) |=> (frame_peak_ff == $past(cand)))
        else $error("Frame peak not captured at frame end");

    AST_FRAME_CLR: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        pc_clear_bit_ff[*2] |-> (frame_peak_ff == PCM_PC_RST))
        else $error("Frame peak not cleared by clear bit");

    AST_MAX_KEEP: assert property (@(posedge hclk) disable iff (!hresetn) // R10
        !released |=> (alltime_peak_ff >= $past(alltime_peak_ff)))
        else $error("All-time peak dropped without clear");

    AST_MAX_RAISE: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (frame_end && !pc_clear_bit_ff && !released && cand > alltime_peak_ff)
        |=> (alltime_peak_ff == $past(cand)))
        else $error("All-time peak not raised by larger frame peak");

    AST_RD_PC_LO: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        seq_rd_take(PCM_IDX_PC_LO) |=> (hrdata == {16'h0000, $past(pc_ff[15:0])}))
        else $error("Counter low read wrong");

    AST_RD_FP_HI: assert property (@(posedge hclk) disable iff (!hresetn) // R7
        seq_rd_take(PCM_IDX_FP_HI) |=> (hrdata == {24'h000000, $past(frame_peak_ff[23:16])}))
        else $error("Frame peak upper read wrong");

    AST_RD_FP_LO: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        seq_rd_take(PCM_IDX_FP_LO) |=> (hrdata == {16'h0000, $past(frame_peak_ff[15:0])}))
        else $error("Frame peak lower read wrong");

    AST_RD_AT_HI: assert property (@(posedge hclk) disable iff (!hresetn) // R11
        seq_rd_take(PCM_IDX_AT_HI) |=> (hrdata == {24'h000000, $past(alltime_peak_ff[23:16])}))
        else $error("All-time upper read wrong");

    AST_RD_AT_LO: assert property (@(posedge hclk) disable iff (!hresetn) // R12
        seq_rd_take(PCM_IDX_AT_LO) |=> (hrdata == {16'h0000, $past(alltime_peak_ff[15:0])}))
        else $error("All-time lower read wrong");

    ////////////////////////////////////////////////////////////////////////
    // Bus checks; the slave never stalls, so data phases never stretch
    AST_ZERO_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout |=> hreadyout)
        else $error("Slave inserted a wait state");

    AST_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout |-> !hresp)
        else $error("Slave answered with an error response");

    // Read data is taken at the address phase edge and waits for the next read
    AST_RDATA_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> $stable(hrdata))
        else $error("Read data moved without a read");

    AST_RD_UNMAPPED: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (rd_idx < PCM_IDX_PC_HI || rd_idx > PCM_IDX_AT_LO)) |=> (hrdata == PCM_RD_ZERO))
        else $error("Unmapped index did not read zero");

    AST_RD_PC_HI: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        seq_rd_take(PCM_IDX_PC_HI) |=> (hrdata == {24'h000000, $past(pc_ff[23:16])}))
        else $error("Counter high read wrong");

    AST_RD_CLR: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        seq_rd_take(PCM_IDX_CLR) |=> (hrdata == {31'h00000000, $past(pc_clear_bit_ff)}))
        else $error("Clear bit read wrong");

    AST_CLR_KEEP: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        !wr_clr |=> $stable(pc_clear_bit_ff))
        else $error("Clear bit changed without a write");

    ////////////////////////////////////////////////////////////////////////
    // Counter checks
    // Jump beats step; both are ignored while frozen
    AST_JUMP_WINS: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        (!pc_clear_bit_ff && core_jump) |=> (pc_ff == $past(core_target)))
        else $error("Jump did not load the target");

    AST_PC_IDLE: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        (!pc_clear_bit_ff && !core_jump && !core_step) |=> $stable(pc_ff))
        else $error("Counter moved without step or jump");

    // The clear history feeds the release detector for the all-time reset
    AST_CLR_PREV: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        pc_clear_bit_ff |=> clr_prev_ff)
        else $error("Clear history lost");

    ////////////////////////////////////////////////////////////////////////
    // Peak checks; a frame end while frozen must not leak a stale peak
    sequence seq_frame_close;
        frame_end && !pc_clear_bit_ff;
    endsequence

    AST_RUN_RESTART: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        seq_frame_close |=> (run_peak_ff == $past(nxt_pc)))
        else $error("Running peak did not restart at frame end");

    AST_RUN_TRACK: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        (!frame_end && !pc_clear_bit_ff) |=> (run_peak_ff >= $past(pc_ff) && run_peak_ff >= $past(run_peak_ff)))
        else $error("Running peak fell below the counter");

    AST_FRAME_BOUND: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        seq_frame_close |=> (frame_peak_ff >= $past(pc_ff)))
        else $error("Frame peak below the closing counter value");

    AST_FRAME_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        (!frame_end && !pc_clear_bit_ff) |=> $stable(frame_peak_ff))
        else $error("Frame peak moved inside a frame");

    AST_RUN_CLR: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        pc_clear_bit_ff |=> (run_peak_ff == PCM_PC_RST))
        else $error("Running peak not cleared by clear bit");

    AST_MAX_ABOVE: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (frame_end && !pc_clear_bit_ff && !released) |=> (alltime_peak_ff >= frame_peak_ff))
        else $error("All-time peak below the frame peak");

    AST_MAX_FROZEN: assert property (@(posedge hclk) disable iff (!hresetn) // R10
        pc_clear_bit_ff |=> $stable(alltime_peak_ff))
        else $error("All-time peak moved while frozen");

    // The core sees zero from the second edge of a freeze onward
    AST_PC_OUT_FROZEN: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        pc_clear_bit_ff[*2] |-> (pc_value == PCM_PC_RST))
        else $error("Counter output not zero while frozen");

endmodule : pcm_monitor

/* File: verif/testbench.sv */
// Self-checking bench for the program counter monitor: bus reads, core stimulus, clear.
// Assumes one AHB-Lite master here, hready tied to hreadyout, zero wait slave.
`timescale 1ns/1ps
module testbench;
    import pcm_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, core_step, core_jump, frame_end;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, pc_frozen;
    logic [23:0] core_target, pc_value;
    int          err_total, samples_checked, cycles;
    pcm_monitor i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_step(core_step), .core_jump(core_jump),
        .core_target(core_target), .frame_end(frame_end), .pc_value(pc_value), .pc_frozen(pc_frozen));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge hclk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            err_total = err_total + 1;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    // One single word transfer; waits on hready, never assumes a latency
    task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {14'h0000, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        ahb(1'b1, idx, wd, rd);
    endtask : wr
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, idx, 32'h00000000, rd);
        chk(rd, exp);
        chk({31'h00000000, hresp}, 32'h00000000);
    endtask : rd_chk
    // Holds the core inputs for n sampling edges, then drops jump, step and frame end
    task automatic core(input logic jmp, input logic [23:0] tgt, input logic stp, input logic fe, input int n);
        @(posedge hclk);
        core_jump   <= jmp;
        core_target <= tgt;
        core_step   <= stp;
        frame_end   <= fe;
        repeat (n) @(posedge hclk);
        core_jump <= 1'b0;
        core_step <= 1'b0;
        frame_end <= 1'b0;
    endtask : core
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        for (int i = 0; i < 7; i++)
            rd_chk(PCM_IDX_PC_HI + 16'(i), 32'h00000000);
        rd_chk(16'hf470, 32'h00000000);
        chk({8'h00, pc_value}, 32'h00000000);
        chk({31'h00000000, pc_frozen}, 32'h00000000);
    endtask : test_reset
    task automatic test_count;
        core(1'b1, 24'h00fffe, 1'b0, 1'b0, 1);
        core(1'b0, 24'h000000, 1'b1, 1'b0, 5);
        rd_chk(PCM_IDX_PC_LO, 32'h00000003);
        rd_chk(PCM_IDX_PC_HI, 32'h00000001);
        chk({8'h00, pc_value}, 32'h00010003);
        core(1'b1, 24'h000100, 1'b1, 1'b0, 1);
        rd_chk(PCM_IDX_PC_LO, 32'h00000100);
    endtask : test_count
    task automatic test_peaks;
        core(1'b1, 24'h123456, 1'b0, 1'b0, 1);
        core(1'b1, 24'h000010, 1'b0, 1'b0, 1);
        core(1'b0, 24'h000000, 1'b0, 1'b1, 1);
        rd_chk(PCM_IDX_FP_HI, 32'h00000012);
        rd_chk(PCM_IDX_FP_LO, 32'h00003456);
        rd_chk(PCM_IDX_AT_LO, 32'h00003456);
        core(1'b1, 24'h000020, 1'b0, 1'b0, 1);
        core(1'b0, 24'h000000, 1'b0, 1'b1, 1);
        rd_chk(PCM_IDX_FP_LO, 32'h00000020);
        rd_chk(PCM_IDX_AT_HI, 32'h00000012);
        rd_chk(PCM_IDX_AT_LO, 32'h00003456);
        core(1'b1, 24'h200000, 1'b0, 1'b0, 1);
        core(1'b0, 24'h000000, 1'b0, 1'b1, 1);
        rd_chk(PCM_IDX_AT_HI, 32'h00000020);
        rd_chk(PCM_IDX_AT_LO, 32'h00000000);
        wr(PCM_IDX_PC_LO, 32'h0000ffff);
        rd_chk(PCM_IDX_PC_LO, 32'h00000000);
    endtask : test_peaks
    task automatic test_clear;
        // Reserved bits are not stored, so all ones reads back as one
        wr(PCM_IDX_CLR, 32'hffffffff);
        rd_chk(PCM_IDX_CLR, 32'h00000001);
        core(1'b0, 24'h000000, 1'b1, 1'b1, 3);
        rd_chk(PCM_IDX_PC_LO, 32'h00000000);
        rd_chk(PCM_IDX_PC_HI, 32'h00000000);
        rd_chk(PCM_IDX_FP_HI, 32'h00000000);
        rd_chk(PCM_IDX_FP_LO, 32'h00000000);
        chk({31'h00000000, pc_frozen}, 32'h00000001);
        wr(PCM_IDX_CLR, 32'h00000000);
        core(1'b0, 24'h000000, 1'b1, 1'b0, 2);
        rd_chk(PCM_IDX_PC_LO, 32'h00000002);
        rd_chk(PCM_IDX_AT_HI, 32'h00000000);
        rd_chk(PCM_IDX_AT_LO, 32'h00000000);
    endtask : test_clear
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        hresetn = 1'b0;
        {hsel, hwrite, core_step, core_jump, frame_end} = 5'h00;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'b00;
        hsize = 3'h2;
        core_target = 24'h000000;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_count();
        test_peaks();
        test_clear();
        finish_test();
    end
endmodule : testbench
